// ---- cta_cpu_host.sv ----
`timescale 1ns/1ns
module cta_cpu_host (
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // command from the bench
    input  wire logic              go_i,
    input  wire cta_pkg::cta_req_t req_i,
    // aperture port
    output logic                   cpu_valid_o,
    output cta_pkg::cta_req_t      cpu_req_o,
    input  wire logic              cpu_ready_i
);
    initial cpu_valid_o = 1'b0;
    initial cpu_req_o = '0;
    // only cpu aperture traffic is ever issued here
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            cpu_valid_o <= 1'b0;
        end else if (cpu_valid_o && cpu_ready_i) begin
            cpu_valid_o <= 1'b0;
            cpu_req_o   <= ~cpu_req_o; // idle bus must not look like the last request
        end else if (go_i && !cpu_valid_o) begin
            cpu_valid_o <= 1'b1;
            cpu_req_o   <= req_i;
        end
    end
endmodule // cta_cpu_host

// ---- cta_pkg.sv ----
package cta_pkg;

    // region table geometry
    localparam int unsigned NUM_REGIONS      = 16;
    localparam int unsigned IDX_W            = 4;
    localparam logic [15:0] TABLE_BASE       = 16'h3000;
    localparam logic [15:0] TABLE_LAST       = 16'h307F;

    // entry field positions
    localparam int unsigned UPPER_MSB        = 63;
    localparam int unsigned UPPER_LSB        = 44;
    localparam int unsigned LOWER_MSB        = 31;
    localparam int unsigned LOWER_LSB        = 12;
    localparam int unsigned PITCH_MSB        = 11;
    localparam int unsigned PITCH_LSB        = 2;
    localparam int unsigned WALK_BIT         = 1;
    localparam int unsigned VALID_BIT        = 0;
    localparam logic [63:0] ENTRY_RESET      = 64'h0000_0000_0000_0000;
    localparam logic [63:0] ENTRY_WMASK      = 64'hFFFF_F000_FFFF_FFFF;

    // tile geometry
    localparam int unsigned TILE_BYTES       = 4096;
    localparam int unsigned X_ROWS           = 8;
    localparam int unsigned Y_ROWS           = 32;
    localparam int unsigned X_ROW_BYTES      = 512;
    localparam int unsigned Y_ROW_BYTES      = 128;
    localparam int unsigned PITCH_UNIT_BYTES = 128;
    localparam int unsigned X_UNIT_BYTES     = 32;
    localparam int unsigned Y_UNIT_BYTES     = 16;
    localparam logic        X_MAJOR_WALK     = 1'b0;
    localparam logic        Y_MAJOR_WALK     = 1'b1;
    localparam logic        REGION_VALID     = 1'b1;
    localparam logic        REGION_INVALID   = 1'b0;

    // pipeline timing: one cycle to capture the request, one cycle lookup and translate
    localparam int unsigned XLAT_LATENCY     = 2;

    typedef struct packed {
        logic [19:0] upper_page;
        logic [11:0] rsvd;
        logic [19:0] lower_page;
        logic [9:0]  pitch;
        logic        tile_walk_format;
        logic        region_valid_format;
    } cta_entry_t;

    typedef struct packed {
        logic        write;
        logic [31:0] aperture_offset;
        logic [7:0]  tag;
    } cta_req_t;

    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic [7:0]  tag;
        logic        tiled;
    } cta_mem_t;

endpackage

// ---- cta_tile_xlat.sv ----
`timescale 1ns/1ns
module cta_tile_xlat (
    // linear offset relative to region start
    input  wire logic [31:0] lin_i,
    input  wire logic [31:0] base_i,
    // region shape
    input  wire logic [9:0]  pitch_i,
    input  wire logic        walk_i,
    // tiled address
    output logic      [31:0] addr_o
);
    logic [31:0] pitch_b;
    logic [31:0] row;
    logic [31:0] col;
    logic [31:0] tiles_per_row;
    logic [31:0] tile_row;
    logic [31:0] tile_col;
    logic [31:0] in_row;
    logic [31:0] in_col;
    logic [31:0] tile_idx;
    logic [31:0] inner;

    always_comb begin
        pitch_b       = (32'(pitch_i) + 32'd1) * 32'(cta_pkg::PITCH_UNIT_BYTES); // R10
        row           = lin_i / pitch_b;
        col           = lin_i - row * pitch_b;
        if (walk_i == cta_pkg::X_MAJOR_WALK) begin
            // x tiles: 512 byte rows, 8 rows per 4 KB tile
            tiles_per_row = pitch_b / 32'(cta_pkg::X_ROW_BYTES); // R5
            tile_row      = row / 32'(cta_pkg::X_ROWS); // R4
            in_row        = row % 32'(cta_pkg::X_ROWS);
            tile_col      = col / 32'(cta_pkg::X_ROW_BYTES);
            in_col        = col % 32'(cta_pkg::X_ROW_BYTES);
            inner         = in_row * 32'(cta_pkg::X_ROW_BYTES) + in_col; // R12
        end else begin
            // y tiles: 16 byte units run down 32 rows, then next column
            tiles_per_row = pitch_b / 32'(cta_pkg::Y_ROW_BYTES); // R5
            tile_row      = row / 32'(cta_pkg::Y_ROWS); // R4
            in_row        = row % 32'(cta_pkg::Y_ROWS);
            tile_col      = col / 32'(cta_pkg::Y_ROW_BYTES);
            in_col        = col % 32'(cta_pkg::Y_ROW_BYTES);
            inner         = (in_col / 32'(cta_pkg::Y_UNIT_BYTES)) * 32'(cta_pkg::Y_UNIT_BYTES * cta_pkg::Y_ROWS)
                          + in_row * 32'(cta_pkg::Y_UNIT_BYTES)
                          + (in_col % 32'(cta_pkg::Y_UNIT_BYTES)); // R12
        end
        tile_idx = tile_row * tiles_per_row + tile_col;
        addr_o   = base_i + tile_idx * 32'(cta_pkg::TILE_BYTES) + inner; // R3 R4
    end
endmodule // cta_tile_xlat

// ---- cta_translator.sv ----
`timescale 1ns/1ns
// How it works
// R1: only accesses from the cpu aperture port are translated; no other requester reaches this table.
// R2: each access offset is compared against every entry's lower and upper page bounds.
// R3: a hit builds the tiled address from the matching entry's walk and pitch.
// R4: a tile is 4 KB, 8 rows tall for x-major and 32 rows for y-major.
// R5: tile rows are 512 bytes wide for x-major and 128 bytes for y-major.
// R6: changing an entry's bounds flushes any access not yet accepted downstream, whichever entry it hits.
// R7: entries survive the graphics reset and clear only on the full chipset reset.
// R8: entry bits 63:44 hold the last page of the region, inclusive.
// R9: entry bits 31:12 hold the first page of the region, inclusive.
// R10: pitch bits 11:2 mean (value+1) times 128 bytes.
// R11: software keeps x-major pitch a multiple of 512 bytes and y-major a multiple of 128 bytes.
// R12: bit 1 picks the walk, 0 for 32-byte units along x, 1 for 16-byte units along y.
// R13: bit 0 set makes the entry take part in matching; clear means ignored.
// R14: software keeps region bounds on 4 KB boundaries.
// R15: per-surface tiled surfaces reached here keep a tile-row-aligned base.
// R16: sixteen 64-bit entries sit consecutively from offset 0x3000.
// R17: an access hitting no valid region goes out with its linear address.
module cta_translator (
    // clock and resets
    input  wire logic                clk_sys_i,
    input  wire logic                sys_rst_i,
    input  wire logic                gfx_rst_i,
    // register port, dword wide, byte address
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [15:0]         reg_addr_i,
    input  wire logic [31:0]         reg_wdata_i,
    output logic      [31:0]         reg_rdata_o,
    output logic                     reg_rvalid_o,
    // cpu aperture requests
    input  wire logic                cpu_valid_i,
    input  wire cta_pkg::cta_req_t   cpu_req_i,
    output logic                     cpu_ready_o,
    // translated memory requests
    output logic                     mem_valid_o,
    output cta_pkg::cta_mem_t        mem_req_o,
    input  wire logic                mem_ready_i,
    // status
    output logic                     flush_o
);
    typedef enum logic [1:0] {
        CTA_IDLE  = 2'b00,
        CTA_LOOK  = 2'b01,
        CTA_SEND  = 2'b11
    } cta_state_t;

    function automatic logic in_table(input logic [15:0] a);
        in_table = (a >= cta_pkg::TABLE_BASE) && (a <= cta_pkg::TABLE_LAST) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [3:0] entry_idx(input logic [15:0] a);
        entry_idx = a[6:3];
    endfunction

    // region table
    cta_pkg::cta_entry_t table_q [cta_pkg::NUM_REGIONS];
    cta_pkg::cta_entry_t table_d [cta_pkg::NUM_REGIONS];
    logic [cta_pkg::NUM_REGIONS-1:0] bound_wr;
    logic [cta_pkg::NUM_REGIONS-1:0] hit_vec;
    // held access, declared here because the page compare below reads it
    cta_pkg::cta_req_t               pend_q;

    genvar g;
    generate
        for (g = 0; g < cta_pkg::NUM_REGIONS; g++) begin : g_entry
            logic [63:0] cur;
            logic [63:0] nxt;
            logic        sel;
            always_comb begin
                cur = table_q[g];
                nxt = cur;
                sel = reg_wr_i && in_table(reg_addr_i) && (entry_idx(reg_addr_i) == 4'(g)); // R16
                bound_wr[g] = 1'b0;
                if (sel) begin
                    if (reg_addr_i[2]) begin
                        nxt[63:32] = reg_wdata_i & cta_pkg::ENTRY_WMASK[63:32]; // R8
                        bound_wr[g] = (reg_wdata_i[31:12] != cur[63:44]); // R6
                    end else begin
                        nxt[31:0] = reg_wdata_i; // R9 R10 R12 R13
                        bound_wr[g] = (reg_wdata_i[31:12] != cur[31:12]); // R6
                    end
                end
                table_d[g] = nxt;
            end
            // only the chipset reset clears entries; gfx_rst_i is ignored here
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i) begin
                    table_q[g] <= cta_pkg::ENTRY_RESET; // R7
                end else begin
                    table_q[g] <= table_d[g];
                end
            end
            // inclusive page compare on the held offset
            assign hit_vec[g] = table_q[g].region_valid_format                   // R13
                             && (pend_q.aperture_offset[31:12] >= table_q[g].lower_page)  // R2 R9
                             && (pend_q.aperture_offset[31:12] <= table_q[g].upper_page); // R2 R8
        end
    endgenerate

    // register readback
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        rvalid_d;
    logic        rvalid_q;
    logic [63:0] rd_entry;
    // data holds between reads so a slow reader can still pick it up
    always_comb begin
        rd_entry = table_q[entry_idx(reg_addr_i)];
        rdata_d  = rdata_q;
        rvalid_d = reg_rd_i;
        if (reg_rd_i) begin
            rdata_d = 32'h0000_0000;
            if (in_table(reg_addr_i)) begin
                rdata_d = reg_addr_i[2] ? rd_entry[63:32] : rd_entry[31:0];
            end
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end
    assign reg_rdata_o  = rdata_q;
    assign reg_rvalid_o = rvalid_q;

    // access pipeline, cleared by either reset
    cta_state_t        state_q;
    cta_state_t        state_d;
    cta_pkg::cta_req_t pend_d;
    cta_pkg::cta_mem_t out_q;
    cta_pkg::cta_mem_t out_d;
    logic              flush_q;
    logic              flush_d;
    logic              any_hit;
    logic [3:0]        hit_idx;
    logic [31:0]       tiled_addr;
    logic [31:0]       region_base;
    logic [31:0]       region_lin;
    logic              any_bound_wr;

    // lowest numbered hit wins if software overlaps regions
    always_comb begin
        any_hit = 1'b0;
        hit_idx = 4'h0;
        for (int i = cta_pkg::NUM_REGIONS - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                any_hit = 1'b1;
                hit_idx = 4'(i);
            end
        end
        region_base = {table_q[hit_idx].lower_page, 12'h000};
        region_lin  = pend_q.aperture_offset - region_base;
    end

    cta_tile_xlat u_xlat (
        .lin_i   (region_lin),
        .base_i  (region_base),
        .pitch_i (table_q[hit_idx].pitch),
        .walk_i  (table_q[hit_idx].tile_walk_format),
        .addr_o  (tiled_addr)
    );

    assign any_bound_wr = |bound_wr;

    always_comb begin
        state_d = state_q;
        pend_d  = pend_q;
        out_d   = out_q;
        flush_d = 1'b0;
        case (state_q)
            CTA_IDLE: begin
                if (cpu_valid_i) begin
                    pend_d  = cpu_req_i; // R1
                    state_d = CTA_LOOK;
                end
            end
            CTA_LOOK: begin
                out_d.write = pend_q.write;
                out_d.tag   = pend_q.tag;
                out_d.tiled = any_hit;
                out_d.addr  = any_hit ? tiled_addr : pend_q.aperture_offset; // R3 R17
                state_d     = CTA_SEND;
            end
            CTA_SEND: begin
                if (mem_ready_i) begin
                    state_d = CTA_IDLE;
                end
            end
            default: begin
                state_d = CTA_IDLE;
            end
        endcase
        // a bound change drops any translation not yet accepted downstream
        if (any_bound_wr && (state_q != CTA_IDLE) && !(state_q == CTA_SEND && mem_ready_i)) begin
            flush_d = 1'b1; // R6
            state_d = CTA_IDLE;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || gfx_rst_i) begin
            state_q <= CTA_IDLE;
            pend_q  <= '0;
            out_q   <= '0;
            flush_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pend_q  <= pend_d;
            out_q   <= out_d;
            flush_q <= flush_d;
        end
    end

    assign cpu_ready_o = (state_q == CTA_IDLE);
    assign mem_valid_o = (state_q == CTA_SEND);
    assign mem_req_o   = out_q;
    assign flush_o     = flush_q;
endmodule // cta_translator

// ---- cta_translator_properties.sv ----
`timescale 1ns/1ns
module cta_translator_properties (
    // clock and resets
    input wire logic              clk_sys_i,
    input wire logic              sys_rst_i,
    input wire logic              gfx_rst_i,
    // register port
    input wire logic              reg_wr_i,
    input wire logic              reg_rd_i,
    input wire logic [15:0]       reg_addr_i,
    input wire logic [31:0]       reg_wdata_i,
    input wire logic [31:0]       reg_rdata_o,
    input wire logic              reg_rvalid_o,
    // cpu and memory sides
    input wire logic              cpu_valid_i,
    input wire cta_pkg::cta_req_t cpu_req_i,
    input wire logic              cpu_ready_o,
    input wire logic              mem_valid_o,
    input wire cta_pkg::cta_mem_t mem_req_o,
    input wire logic              mem_ready_i,
    input wire logic              flush_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i || gfx_rst_i);
    property p_rv; reg_rd_i |=> reg_rvalid_o; endproperty
    a_rv: assert property (p_rv) else $error("read answer missing");
    property p_un; reg_rd_i && reg_addr_i > cta_pkg::TABLE_LAST |=> reg_rdata_o == 32'h0000_0000; endproperty
    a_un: assert property (p_un) else $error("unmapped read not zero");
    property p_hd; !reg_rvalid_o |-> $stable(reg_rdata_o); endproperty
    a_hd: assert property (p_hd) else $error("read data moved");
    property p_acc; cpu_valid_i && cpu_ready_o |=> !cpu_ready_o; endproperty
    a_acc: assert property (p_acc) else $error("second request accepted");
    // a bound rewrite in lookup may end the access early, so flush stands in
    property p_lat; cpu_valid_i && cpu_ready_o |-> ##[2:3] (mem_valid_o || flush_o); endproperty
    a_lat: assert property (p_lat) else $error("translated request late");
    property p_st; mem_valid_o && !mem_ready_i && !reg_wr_i |=> mem_valid_o && $stable(mem_req_o); endproperty
    a_st: assert property (p_st) else $error("offered request changed");
    property p_hs; mem_valid_o && mem_ready_i |=> !mem_valid_o && cpu_ready_o; endproperty
    a_hs: assert property (p_hs) else $error("handshake not closed");
    property p_fl; flush_o |-> !mem_valid_o ##1 !flush_o; endproperty
    a_fl: assert property (p_fl) else $error("flush kept request");
    property p_fc; flush_o |-> $past(reg_wr_i) || $past(reg_wr_i, 2); endproperty
    a_fc: assert property (p_fc) else $error("flush without write");
endmodule // cta_translator_properties
bind cta_translator cta_translator_properties u_props (.*);

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
    logic clk_sys_i = 0, sys_rst_i = 1, gfx_rst_i = 0, reg_wr_i = 0, reg_rd_i = 0, mem_ready_i = 0, go = 0;
    logic [15:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o, offs[6], bases[4], masks[4];
    logic reg_rvalid_o, cpu_valid_i, cpu_ready_o, mem_valid_o, flush_o, seen;
    cta_pkg::cta_req_t cpu_req_i, hreq = '0;
    cta_pkg::cta_mem_t mem_req_o;
    logic [63:0] ent[16];
    integer err_total = 0, checks_done = 0, cycles = 0, seed = 88582;
    initial forever #2 clk_sys_i = ~clk_sys_i;
    cta_translator DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .gfx_rst_i(gfx_rst_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .cpu_valid_i(cpu_valid_i),
        .cpu_req_i(cpu_req_i), .cpu_ready_o(cpu_ready_o), .mem_valid_o(mem_valid_o),
        .mem_req_o(mem_req_o), .mem_ready_i(mem_ready_i), .flush_o(flush_o));
    cta_cpu_host u_host (.clk_sys_i(clk_sys_i), .rst_i(sys_rst_i), .go_i(go), .req_i(hreq),
        .cpu_valid_o(cpu_valid_i), .cpu_req_o(cpu_req_i), .cpu_ready_i(cpu_ready_o));
    task automatic conclude;
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_total = err_total + 1;
            conclude();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: saw %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic mapped(input logic [15:0] a);
        return a >= cta_pkg::TABLE_BASE && a <= cta_pkg::TABLE_LAST && a[1:0] == 2'b00;
    endfunction
    // lowest valid entry wins; a miss keeps the linear offset
    function automatic logic [32:0] model(input logic [31:0] off);
        int unsigned p, lin, x, y, b, w, h;
        for (int n = 0; n < 16; n++) begin
            if (ent[n][0] && off[31:12] >= ent[n][31:12] && off[31:12] <= ent[n][63:44]) begin
                b = {ent[n][31:12], 12'h000};
                lin = off - b;
                p = (ent[n][11:2] + 1) * 128;
                y = lin / p;
                x = lin % p;
                w = ent[n][1] ? 128 : 512;
                h = 4096 / w;
                return {1'b1, b + (y / h * (p / w) + x / w) * 4096
                    + (ent[n][1] ? (x % w) / 16 * 512 + (y % h) * 16 + x % 16 : (y % h) * 512 + x % w)};
            end
        end
        return {1'b0, off};
    endfunction
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        if (mapped(a)) ent[a[6:3]][a[2]*32 +: 32] = d & cta_pkg::ENTRY_WMASK[a[2]*32 +: 32];
    endtask
    task automatic rd(input logic [15:0] a);
        logic [31:0] e;
        e = mapped(a) ? ent[a[6:3]][a[2]*32 +: 32] : 32'h0000_0000;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rvalid_o, 1'b1);
        chk(reg_rdata_o, e);
    endtask
    task automatic issue(input logic [31:0] off);
        @(posedge clk_sys_i);
        go <= 1'b1;
        hreq <= '{write: off[0], aperture_offset: off, tag: off[9:2]};
        @(posedge clk_sys_i);
        go <= 1'b0;
    endtask
    task automatic acc(input logic [31:0] off);
        logic [32:0] e;
        e = model(off);
        issue(off);
        #1;
        repeat (12) if (mem_valid_o !== 1'b1) @(posedge clk_sys_i) #1;
        repeat ($unsigned($random(seed)) % 4) @(posedge clk_sys_i);
        #1;
        chk(mem_req_o.addr, e[31:0]);
        chk({mem_req_o.tiled, mem_req_o.write, mem_req_o.tag}, {e[32], off[0], off[9:2]});
        @(posedge clk_sys_i);
        mem_ready_i <= 1'b1;
        @(posedge clk_sys_i);
        mem_ready_i <= 1'b0;
    endtask
    initial begin
        foreach (ent[n]) ent[n] = '0;
        offs = '{32'h0010_0000, 32'h0010_7FFF, 32'h0010_8000, 32'h000F_FFFC, 32'h0020_3FF1, 32'h0041_FFF8};
        bases = '{32'h0010_0000, 32'h0020_0000, 32'h0040_0000, 32'h0080_0000};
        masks = '{32'h0000_7FFF, 32'h0000_3FFF, 32'h0001_FFFF, 32'h000F_FFFF};
        repeat (4) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        // page-aligned bounds, x pitch in 512 byte steps; entry 1 overlaps but is invalid
        wr(16'h3008, 32'h0010_000E);
        wr(16'h300C, 32'h0010_7000);
        wr(16'h3010, 32'h0010_001D);
        wr(16'h3014, 32'h0010_7FFF);
        wr(16'h3028, 32'h0020_0007);
        wr(16'h302C, 32'h0020_3000);
        wr(16'h3078, 32'h0040_0FFD);
        wr(16'h307C, 32'h0041_F000);
        wr(16'h3080, 32'hFFFF_FFFF);
        for (int i = 0; i < 32; i++) rd(16'h3000 + 16'(4 * i));
        rd(16'h3080);
        rd(16'h3012);
        foreach (offs[i]) acc(offs[i]);
        for (int i = 0; i < 24; i++) acc(bases[i % 4] | ($random(seed) & masks[i % 4]));
        // a bound rewrite while the access waits must drop it
        issue(32'h0010_0040);
        repeat (3) @(posedge clk_sys_i);
        wr(16'h3010, 32'h0010_101D);
        #1 seen = flush_o;
        repeat (3) @(posedge clk_sys_i) #1 seen = seen | flush_o;
        chk({seen, mem_valid_o, cpu_ready_o}, 3'b101);
        acc(32'h0010_1234);
        @(posedge clk_sys_i);
        gfx_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        gfx_rst_i <= 1'b0;
        rd(16'h3010);
        acc(32'h0010_2345);
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        foreach (ent[n]) ent[n] = '0;
        rd(16'h3010);
        acc(32'h0010_2345);
        conclude();
    end
endmodule // tb
